// ---- core/acrb_pkg.sv ----
// Purpose: Constants for the converter configuration register bank
// Assumes: 16-bit serial words, address byte first, MSB first
// Notes:   Unlisted addresses read as zero and ignore writes
package acrb_pkg;

	localparam int unsigned   ACRB_WORD_BITS   = 16;
	localparam int unsigned   ACRB_ADDR_BITS   = 8;
	localparam logic [4:0]    ACRB_CNT_LAST    = 5'h0f;
	localparam logic [4:0]    ACRB_CNT_ADDR    = 5'h07;
	localparam logic [4:0]    ACRB_CNT_DONE    = 5'h10;

	// Register offsets
	localparam logic [7:0]    ACRB_OFS_RESET_READ   = 8'h00;
	localparam logic [7:0]    ACRB_OFS_LOW_SPEED    = 8'h20;
	localparam logic [7:0]    ACRB_OFS_POWER_REF    = 8'h3f;
	localparam logic [7:0]    ACRB_OFS_OUT_IFACE    = 8'h41;
	localparam logic [7:0]    ACRB_OFS_CLK_EDGE     = 8'h44;
	localparam logic [7:0]    ACRB_OFS_CODING       = 8'h50;

	// Writable bit masks; fixed-zero positions are never stored
	localparam logic [7:0]    ACRB_MASK_RESET_READ  = 8'h01;
	localparam logic [7:0]    ACRB_MASK_LOW_SPEED   = 8'h04;
	localparam logic [7:0]    ACRB_MASK_POWER_REF   = 8'h67;
	localparam logic [7:0]    ACRB_MASK_OUT_IFACE   = 8'hc0;
	localparam logic [7:0]    ACRB_MASK_CLK_EDGE    = 8'hfc;
	localparam logic [7:0]    ACRB_MASK_CODING      = 8'h06;
	localparam logic [7:0]    ACRB_REG_RESET_VAL    = 8'h00;

	// Field positions
	localparam int unsigned   ACRB_BIT_SOFT_RESET   = 7;
	localparam int unsigned   ACRB_BIT_READOUT      = 0;
	localparam int unsigned   ACRB_BIT_LOW_SPEED    = 2;
	localparam int unsigned   ACRB_BIT_OBUF_PDN     = 0;
	localparam int unsigned   ACRB_BIT_STANDBY      = 1;
	localparam int unsigned   ACRB_BIT_GLOBAL_PDN   = 2;
	localparam int unsigned   ACRB_REF_MSB          = 6;
	localparam int unsigned   ACRB_REF_LSB          = 5;
	localparam int unsigned   ACRB_IF_MSB           = 7;
	localparam int unsigned   ACRB_IF_LSB           = 6;
	localparam int unsigned   ACRB_RISE_MSB         = 7;
	localparam int unsigned   ACRB_RISE_LSB         = 5;
	localparam int unsigned   ACRB_FALL_MSB         = 4;
	localparam int unsigned   ACRB_FALL_LSB         = 2;
	localparam int unsigned   ACRB_FMT_MSB          = 2;
	localparam int unsigned   ACRB_FMT_LSB          = 1;

	// Field codes
	localparam logic [1:0]    ACRB_REF_PIN          = 2'h0;
	localparam logic [1:0]    ACRB_REF_INTERNAL     = 2'h1;
	localparam logic [1:0]    ACRB_REF_EXTERNAL     = 2'h3;
	localparam logic [1:0]    ACRB_IF_PIN           = 2'h0;
	localparam logic [1:0]    ACRB_IF_LVDS          = 2'h2;
	localparam logic [1:0]    ACRB_IF_CMOS          = 2'h3;
	localparam logic [1:0]    ACRB_FMT_PIN          = 2'h0;
	localparam logic [1:0]    ACRB_FMT_TWOS         = 2'h2;
	localparam logic [1:0]    ACRB_FMT_OFFSET       = 2'h3;
	localparam logic [2:0]    ACRB_EDGE_DEF0        = 3'h0;
	localparam logic [2:0]    ACRB_EDGE_DEF4        = 3'h4;
	localparam logic [2:0]    ACRB_EDGE_CODE5       = 3'h5;
	localparam logic [2:0]    ACRB_EDGE_CODE6       = 3'h6;
	localparam logic [2:0]    ACRB_EDGE_CODE7       = 3'h7;

	// Edge shifts in 26ths of a sample period
	localparam logic signed [4:0] ACRB_SHIFT_ZERO   = 5'sh00;
	localparam logic signed [4:0] ACRB_SHIFT_4      = 5'sh04;
	localparam logic signed [4:0] ACRB_SHIFT_M4     = 5'sh1c;
	localparam logic signed [4:0] ACRB_SHIFT_6      = 5'sh06;

endpackage : acrb_pkg

// ---- core/acrb_top.sv ----
// Purpose: Serially programmed configuration register bank of the converter
// Assumes: Serial pins are synchronous to mclk and slower than mclk / 2
// Notes:   Decoded controls update the cycle after a serial word completes
`timescale 1ns/1ps

module acrb_top
	import acrb_pkg::*;
(
	input  wire logic               mclk,                    // System clock, 100 MHz
	input  wire logic               sys_rst,                 // Synchronous reset, high
	input  wire logic               serial_enable_n,         // Serial frame select, low
	input  wire logic               serial_clk,              // Serial bit clock
	input  wire logic               serial_data,             // Serial data in
	input  wire logic               adc_overflow,            // Converter overflow flag
	input  wire logic               format_select_pin_iface, // Pin choice: 1 = CMOS
	input  wire logic               format_select_pin_coding,// Pin choice: 1 = offset binary
	input  wire logic               ref_mode_pin_external,   // Pin choice: 1 = external ref
	output logic                    overflow_serial_out_pin, // Overflow or readout data
	output logic                    low_speed_mode,          // Low-speed mode enable
	output logic                    output_buffer_powerdown, // Output buffer off
	output logic                    core_powerdown,          // Converter core off
	output logic                    reference_powerdown,     // Internal references off
	output logic                    quick_wake,              // Core down with refs kept up
	output logic                    external_reference,      // External reference in use
	output logic                    cmos_mode,               // 1 CMOS, 0 DDR LVDS
	output logic signed [4:0]       rise_shift_26ths,        // Rising edge shift, Ts/26
	output logic                    rise_aligned,            // Rising edge on data edge
	output logic signed [4:0]       fall_shift_26ths,        // Falling edge shift, Ts/26
	output logic                    offset_binary            // 1 offset binary, 0 twos
);

	logic                           sclk_prev_r;
	logic [4:0]                     bit_cnt_r;
	logic [ACRB_WORD_BITS-1:0]      shift_r;
	logic [7:0]                     rd_shift_r;
	logic                           wr_stb;
	logic                           addr_stb;
	logic                           sclk_rise;
	logic                           sclk_fall;
	logic [ACRB_WORD_BITS-1:0]      word;
	logic [7:0]                     reg_reset_read_r;
	logic [7:0]                     reg_low_speed_r;
	logic [7:0]                     reg_power_ref_r;
	logic [7:0]                     reg_out_iface_r;
	logic [7:0]                     reg_clk_edge_r;
	logic [7:0]                     reg_coding_r;
	logic [7:0]                     rd_data;
	logic                           readout_en;
	logic [1:0]                     ref_code;
	logic [1:0]                     if_code;
	logic [1:0]                     fmt_code;
	logic [2:0]                     rise_code;
	logic [2:0]                     fall_code;
	logic                           iface_cmos;

	assign sclk_rise  = serial_clk & ~sclk_prev_r;
	assign sclk_fall  = ~serial_clk & sclk_prev_r;
	assign word       = {shift_r[ACRB_WORD_BITS-2:0], serial_data};
	assign wr_stb     = sclk_rise & ~serial_enable_n & (bit_cnt_r == ACRB_CNT_LAST);
	assign addr_stb   = sclk_rise & ~serial_enable_n & (bit_cnt_r == ACRB_CNT_ADDR);
	assign readout_en = reg_reset_read_r[ACRB_BIT_READOUT];
	assign ref_code   = reg_power_ref_r[ACRB_REF_MSB:ACRB_REF_LSB];
	assign if_code    = reg_out_iface_r[ACRB_IF_MSB:ACRB_IF_LSB];
	assign fmt_code   = reg_coding_r[ACRB_FMT_MSB:ACRB_FMT_LSB];
	assign rise_code  = reg_clk_edge_r[ACRB_RISE_MSB:ACRB_RISE_LSB];
	assign fall_code  = reg_clk_edge_r[ACRB_FALL_MSB:ACRB_FALL_LSB];

	// Serial shifter: bits past the sixteenth of a frame are ignored
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			sclk_prev_r <= 1'b0;
			bit_cnt_r   <= 5'h00;
			shift_r     <= 16'h0000;
		end
		else
		begin
			sclk_prev_r <= serial_clk;
			if (serial_enable_n)
				bit_cnt_r <= 5'h00;
			else if (sclk_rise && bit_cnt_r != ACRB_CNT_DONE)
			begin
				bit_cnt_r <= bit_cnt_r + 5'h01;
				shift_r   <= word;
			end
		end
	end

	// Register file; a set software-reset bit clears everything and is not kept
	always_ff @(posedge mclk)
	begin
		if (sys_rst || (wr_stb && word[15:8] == ACRB_OFS_RESET_READ
			&& word[ACRB_BIT_SOFT_RESET]))
		begin
			reg_reset_read_r <= ACRB_REG_RESET_VAL;
			reg_low_speed_r  <= ACRB_REG_RESET_VAL;
			reg_power_ref_r  <= ACRB_REG_RESET_VAL;
			reg_out_iface_r  <= ACRB_REG_RESET_VAL;
			reg_clk_edge_r   <= ACRB_REG_RESET_VAL;
			reg_coding_r     <= ACRB_REG_RESET_VAL;
		end
		else if (wr_stb)
		begin
			// While reading out, only the readout register accepts writes
			unique case (word[15:8])
				ACRB_OFS_RESET_READ: reg_reset_read_r <= word[7:0] & ACRB_MASK_RESET_READ;
				ACRB_OFS_LOW_SPEED:
					if (!readout_en)
						reg_low_speed_r <= word[7:0] & ACRB_MASK_LOW_SPEED;
				ACRB_OFS_POWER_REF:
					if (!readout_en)
						reg_power_ref_r <= word[7:0] & ACRB_MASK_POWER_REF;
				ACRB_OFS_OUT_IFACE:
					if (!readout_en)
						reg_out_iface_r <= word[7:0] & ACRB_MASK_OUT_IFACE;
				ACRB_OFS_CLK_EDGE:
					if (!readout_en)
						reg_clk_edge_r <= word[7:0] & ACRB_MASK_CLK_EDGE;
				ACRB_OFS_CODING:
					if (!readout_en)
						reg_coding_r <= word[7:0] & ACRB_MASK_CODING;
				default: ;
			endcase
		end
	end

	// Readback selection for the address byte just received
	always_comb
	begin
		unique case (word[7:0])
			ACRB_OFS_RESET_READ: rd_data = reg_reset_read_r;
			ACRB_OFS_LOW_SPEED:  rd_data = reg_low_speed_r;
			ACRB_OFS_POWER_REF:  rd_data = reg_power_ref_r;
			ACRB_OFS_OUT_IFACE:  rd_data = reg_out_iface_r;
			ACRB_OFS_CLK_EDGE:   rd_data = reg_clk_edge_r;
			ACRB_OFS_CODING:     rd_data = reg_coding_r;
			default:             rd_data = 8'h00;
		endcase
	end

	// Readout: loaded after the address byte, MSB first on falling serial edges
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rd_shift_r              <= 8'h00;
			overflow_serial_out_pin <= 1'b0;
		end
		else
		begin
			if (addr_stb)
				rd_shift_r <= rd_data;
			else if (sclk_fall && !serial_enable_n)
				rd_shift_r <= {rd_shift_r[6:0], 1'b0};
			if (!readout_en)
				overflow_serial_out_pin <= adc_overflow;
			else if (sclk_fall && !serial_enable_n)
				overflow_serial_out_pin <= rd_shift_r[7];
		end
	end

	// Interface choice feeds the clock edge decode
	always_comb
	begin
		unique case (if_code)
			ACRB_IF_LVDS: iface_cmos = 1'b0;
			ACRB_IF_CMOS: iface_cmos = 1'b1;
			default:      iface_cmos = format_select_pin_iface;
		endcase
	end

	// Power, speed, reference and format controls
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			low_speed_mode          <= 1'b0;
			output_buffer_powerdown <= 1'b0;
			core_powerdown          <= 1'b0;
			reference_powerdown     <= 1'b0;
			quick_wake              <= 1'b0;
			external_reference      <= 1'b0;
			cmos_mode               <= 1'b0;
			offset_binary           <= 1'b0;
		end
		else
		begin
			low_speed_mode          <= reg_low_speed_r[ACRB_BIT_LOW_SPEED];
			output_buffer_powerdown <= reg_power_ref_r[ACRB_BIT_OBUF_PDN]
				| reg_power_ref_r[ACRB_BIT_GLOBAL_PDN];
			core_powerdown          <= reg_power_ref_r[ACRB_BIT_STANDBY]
				| reg_power_ref_r[ACRB_BIT_GLOBAL_PDN];
			reference_powerdown     <= reg_power_ref_r[ACRB_BIT_GLOBAL_PDN];
			quick_wake              <= reg_power_ref_r[ACRB_BIT_STANDBY]
				& ~reg_power_ref_r[ACRB_BIT_GLOBAL_PDN];
			unique case (ref_code)
				ACRB_REF_INTERNAL: external_reference <= 1'b0;
				ACRB_REF_EXTERNAL: external_reference <= 1'b1;
				default:           external_reference <= ref_mode_pin_external;
			endcase
			cmos_mode <= iface_cmos;
			unique case (fmt_code)
				ACRB_FMT_TWOS:   offset_binary <= 1'b0;
				ACRB_FMT_OFFSET: offset_binary <= 1'b1;
				default:         offset_binary <= format_select_pin_coding;
			endcase
		end
	end

	// Output clock edge placement
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rise_shift_26ths <= ACRB_SHIFT_ZERO;
			rise_aligned     <= 1'b0;
			fall_shift_26ths <= ACRB_SHIFT_ZERO;
		end
		else
		begin
			rise_shift_26ths <= ACRB_SHIFT_ZERO;
			rise_aligned     <= 1'b0;
			fall_shift_26ths <= ACRB_SHIFT_ZERO;
			if (!iface_cmos)
			begin
				if (rise_code == ACRB_EDGE_CODE5)
					rise_shift_26ths <= ACRB_SHIFT_4;
				if (rise_code == ACRB_EDGE_CODE7)
					rise_shift_26ths <= ACRB_SHIFT_M4;
				if (rise_code == ACRB_EDGE_CODE6)
					rise_aligned <= 1'b1;
			end
			else
			begin
				if (rise_code == ACRB_EDGE_CODE5)
					rise_shift_26ths <= ACRB_SHIFT_4;
				if (rise_code == ACRB_EDGE_CODE6)
					rise_shift_26ths <= ACRB_SHIFT_6;
				if (rise_code == ACRB_EDGE_CODE7)
					rise_aligned <= 1'b1;
				if (fall_code == ACRB_EDGE_CODE5)
					fall_shift_26ths <= ACRB_SHIFT_4;
			end
		end
	end

endmodule : acrb_top

// ---- verif/acrb_chk.sv ----
// Purpose: Port-level assertions for the configuration register bank
// Assumes: Outputs are registered decodes of the stored fields
// Notes:   Bound to the design from the testbench top file
`timescale 1ns/1ps

module acrb_chk
(
	input wire logic              mclk,                    // Clock
	input wire logic              sys_rst,                 // Reset
	input wire logic              serial_enable_n,         // Frame select
	input wire logic              serial_clk,              // Bit clock
	input wire logic              ref_mode_pin_external,   // Reference pin
	input wire logic              low_speed_mode,          // Low speed
	input wire logic              output_buffer_powerdown, // Buffer off
	input wire logic              core_powerdown,          // Core off
	input wire logic              reference_powerdown,     // References off
	input wire logic              quick_wake,              // Standby
	input wire logic              external_reference,      // External ref
	input wire logic              cmos_mode,               // CMOS interface
	input wire logic signed [4:0] rise_shift_26ths,        // Rise shift
	input wire logic              rise_aligned,            // Rise aligned
	input wire logic signed [4:0] fall_shift_26ths         // Fall shift
);
	logic       clk_q_r;
	logic [4:0] bits_r;
	logic [1:0] age_r;
	logic       word_done;
	logic       settled;

	// Sixteenth bit of a frame seen at this edge
	assign word_done = !serial_enable_n && serial_clk && !clk_q_r && bits_r == 5'h0f;
	assign settled   = age_r == 2'h3;

	always_ff @(posedge mclk)
	begin
		clk_q_r <= serial_clk;
		if (sys_rst || serial_enable_n)
			bits_r <= 5'h00;
		else if (serial_clk && !clk_q_r && bits_r != 5'h10)
			bits_r <= bits_r + 5'h01;
	end

	// Masks the pin-driven settling just after a reset
	always_ff @(posedge mclk)
		age_r <= sys_rst ? 2'h0 : (settled ? age_r : age_r + 2'h1);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_global_pdn_all: assert property (
		reference_powerdown |-> output_buffer_powerdown && core_powerdown)
		else $error("global powerdown left a block running");
	a_standby_core_only: assert property (
		quick_wake |-> core_powerdown && !reference_powerdown)
		else $error("standby decode wrong");
	a_aligned_no_shift: assert property (
		rise_aligned |-> rise_shift_26ths == 5'h00)
		else $error("aligned edge also shifted");
	a_fall_cmos_only: assert property (
		fall_shift_26ths != 5'h00 |-> cmos_mode && fall_shift_26ths == 5'h04)
		else $error("falling edge shift wrong");
	a_lvds_rise_set: assert property (
		!cmos_mode |-> rise_shift_26ths inside {5'h00, 5'h04, 5'h1c})
		else $error("LVDS rise shift out of set");
	a_cmos_rise_set: assert property (
		cmos_mode |-> rise_shift_26ths inside {5'h00, 5'h04, 5'h06})
		else $error("CMOS rise shift out of set");
	a_cfg_word_end: assert property (
		settled && $changed({low_speed_mode, output_buffer_powerdown, core_powerdown,
		reference_powerdown, quick_wake}) |-> $past(word_done, 2))
		else $error("control changed without a completed word");
	a_ref_change_cause: assert property (
		settled && $changed(external_reference) |-> $past(word_done, 2)
		|| $past(ref_mode_pin_external) != $past(ref_mode_pin_external, 2))
		else $error("reference choice changed without cause");
endmodule : acrb_chk

// ---- verif/acrb_host.sv ----
// Purpose: Host controller model on the serial programming port
// Assumes: Bit clock phases of several mclk cycles, changes at falling mclk
// Notes:   Data line shows the inverse of its last bit between frames
`timescale 1ns/1ps

module acrb_host
(
	input  wire logic mclk,                    // System clock
	input  wire logic overflow_serial_out_pin, // Readout pin
	output logic      serial_enable_n,         // Frame select
	output logic      serial_clk,              // Bit clock
	output logic      serial_data              // Serial data
);
	initial
	begin
		serial_enable_n = 1'b1;
		serial_clk      = 1'b0;
		serial_data     = 1'b0;
	end

	// Sends n bits of {a, d}; q collects the pin after falls 8 to 15
	task automatic xfer(input logic [7:0] a, input logic [7:0] d, input int n,
		output logic [7:0] q);
		logic [15:0] w;
		w = {a, d};
		q = 8'h00;
		@(negedge mclk) serial_enable_n <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			@(negedge mclk) serial_data <= w[15 - i];
			@(negedge mclk) serial_clk <= 1'b1;
			repeat (2) @(negedge mclk);
			serial_clk <= 1'b0;
			repeat (3) @(negedge mclk);
			if (i >= 7 && i <= 14)
				q = {q[6:0], overflow_serial_out_pin};
		end
		@(negedge mclk) serial_enable_n <= 1'b1;
		serial_data <= ~serial_data;
	endtask : xfer
endmodule : acrb_host

// ---- verif/acrb_top_test.sv ----
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Host model sends frames; expected decode is built here
// Notes:   Random fields from a fixed seed plus directed corner codes
`timescale 1ns/1ps

module acrb_top_test;
	import acrb_pkg::*;
	logic              mclk = 1'b0, sys_rst = 1'b1, adc_overflow = 1'b0;
	logic              format_select_pin_iface = 1'b0, format_select_pin_coding = 1'b0;
	logic              ref_mode_pin_external = 1'b0;
	logic              serial_enable_n, serial_clk, serial_data, overflow_serial_out_pin;
	logic              low_speed_mode, output_buffer_powerdown, core_powerdown;
	logic              reference_powerdown, quick_wake, external_reference, cmos_mode;
	logic              rise_aligned, offset_binary;
	logic signed [4:0] rise_shift_26ths, fall_shift_26ths;
	logic [7:0]        m [5];
	logic [7:0]        q;
	int                error_cnt = 0, samples_checked = 0;
	localparam logic [7:0] OFS [5] = '{ACRB_OFS_LOW_SPEED, ACRB_OFS_POWER_REF,
		ACRB_OFS_OUT_IFACE, ACRB_OFS_CLK_EDGE, ACRB_OFS_CODING};

	always #5 mclk = ~mclk;

	acrb_top i_acrb_top (.mclk, .sys_rst, .serial_enable_n, .serial_clk, .serial_data,
		.adc_overflow, .format_select_pin_iface, .format_select_pin_coding,
		.ref_mode_pin_external, .overflow_serial_out_pin, .low_speed_mode,
		.output_buffer_powerdown, .core_powerdown, .reference_powerdown, .quick_wake,
		.external_reference, .cmos_mode, .rise_shift_26ths, .rise_aligned,
		.fall_shift_26ths, .offset_binary);
	acrb_host i_acrb_host (.mclk, .overflow_serial_out_pin, .serial_enable_n,
		.serial_clk, .serial_data);

	task automatic chk(input string n, input logic [19:0] got, input logic [19:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	function automatic logic [1:0] pick2(input logic [1:0] alt);
		case ($urandom_range(2))
			0: return 2'h0;
			1: return alt;
			default: return 2'h3;
		endcase
	endfunction : pick2

	function automatic logic [2:0] pick3();
		int k;
		k = $urandom_range(4);
		return k == 0 ? 3'h0 : 3'(k + 3);
	endfunction : pick3

	// Listed codes only, fixed-zero positions kept zero
	function automatic logic [7:0] draw(input int k);
		case (k)
			0: return {5'h00, 1'($urandom), 2'h0};
			1: return {1'b0, pick2(2'h1), 2'h0, 3'($urandom)};
			2: return {pick2(2'h2), 6'h00};
			3: return {pick3(), pick3(), 2'h0};
			default: return {5'h00, pick2(2'h2), 1'b0};
		endcase
	endfunction : draw

	function automatic logic [19:0] exp_out(input logic a);
		logic [2:0]        r;
		logic              c;
		logic signed [4:0] s;
		r = m[3][7:5];
		c = m[2][7:6] == 2'h3 ? 1'b1 : m[2][7:6] == 2'h2 ? 1'b0 : format_select_pin_iface;
		s = r == 3'h5 ? 5'h04 : (c && r == 3'h6) ? 5'h06 : (!c && r == 3'h7) ? 5'h1c : 5'h00;
		return {a, m[0][2], m[1][0] | m[1][2], m[1][1] | m[1][2], m[1][2], m[1][1] & ~m[1][2],
			m[1][6:5] == 2'h3 ? 1'b1 : m[1][6:5] == 2'h1 ? 1'b0 : ref_mode_pin_external, c,
			c ? r == 3'h7 : r == 3'h6,
			m[4][2:1] == 2'h3 ? 1'b1 : m[4][2:1] == 2'h2 ? 1'b0 : format_select_pin_coding,
			s, (c && m[3][4:2] == 3'h5) ? 5'h04 : 5'h00};
	endfunction : exp_out

	// New pin levels, then compare every output two edges later
	task automatic chk_out();
		logic        a;
		logic [19:0] g;
		logic [19:0] e;
		a = 1'($urandom);
		@(negedge mclk);
		adc_overflow = a;
		format_select_pin_iface = 1'($urandom);
		format_select_pin_coding = 1'($urandom);
		ref_mode_pin_external = 1'($urandom);
		repeat (2) @(negedge mclk);
		g = {overflow_serial_out_pin, low_speed_mode, output_buffer_powerdown,
			core_powerdown, reference_powerdown, quick_wake, external_reference, cmos_mode,
			rise_aligned, offset_binary, rise_shift_26ths, fall_shift_26ths};
		e = exp_out(a);
		chk("overflow pin", g & 20'h8_0000, e & 20'h8_0000);
		chk("speed and power", g & 20'h7_c000, e & 20'h7_c000);
		chk("ref iface format", g & 20'h0_3400, e & 20'h0_3400);
		chk("rise edge", g & 20'h0_0be0, e & 20'h0_0be0);
		chk("fall edge", g & 20'h0_001f, e & 20'h0_001f);
	endtask : chk_out

	task automatic wr(input int k, input logic [7:0] d);
		i_acrb_host.xfer(OFS[k], d, 16, q);
		m[k] = d;
		chk_out();
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_acrb_host.xfer(ACRB_OFS_RESET_READ, 8'h01, 16, q);
		i_acrb_host.xfer(a, 8'h00, 16, q);
		chk("readback", {12'h000, q}, {12'h000, e});
		i_acrb_host.xfer(ACRB_OFS_RESET_READ, 8'h00, 16, q);
	endtask : rd

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	initial
	begin
		#200us;
		error_cnt++;
		finish_test();
	end

	initial
	begin
		int k;
		void'($urandom(32'h79b9));
		foreach (m[i]) m[i] = 8'h00;
		repeat (20) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (4) chk_out();
		$display("test defaults finished");
		for (int c = 0; c < 2; c++)
			for (int r = 0; r < 5; r++)
			begin
				k = r == 0 ? 0 : r + 3;
				wr(2, {c[0] ? ACRB_IF_CMOS : ACRB_IF_LVDS, 6'h00});
				wr(3, {k[2:0], k[2:0], 2'h0});
			end
		for (int p = 0; p < 8; p++)
			wr(1, {1'b0, p % 3 == 0 ? 2'h0 : p % 3 == 1 ? 2'h1 : 2'h3, 2'h0, p[2:0]});
		repeat (30)
		begin
			k = $urandom_range(4);
			wr(k, draw(k));
		end
		$display("test field codes finished");
		for (int i = 0; i < 5; i++) rd(OFS[i], m[i]);
		rd(8'h30, 8'h00);
		rd(ACRB_OFS_RESET_READ, 8'h01);
		i_acrb_host.xfer(ACRB_OFS_RESET_READ, 8'h01, 16, q);
		i_acrb_host.xfer(ACRB_OFS_POWER_REF, 8'h07, 16, q);
		i_acrb_host.xfer(ACRB_OFS_RESET_READ, 8'h00, 16, q);
		chk_out();
		$display("test readout finished");
		wr(0, 8'h04);
		wr(1, 8'h27);
		i_acrb_host.xfer(ACRB_OFS_LOW_SPEED, 8'h00, 12, q);
		chk_out();
		i_acrb_host.xfer(ACRB_OFS_RESET_READ, 8'h80, 16, q);
		foreach (m[i]) m[i] = 8'h00;
		chk_out();
		rd(ACRB_OFS_RESET_READ, 8'h01);
		wr(3, 8'hb4);
		sys_rst = 1'b1;
		repeat (3) @(negedge mclk);
		sys_rst = 1'b0;
		foreach (m[i]) m[i] = 8'h00;
		chk_out();
		$display("test resets finished");
		finish_test();
	end
endmodule : acrb_top_test

bind acrb_top acrb_chk i_acrb_chk (.mclk, .sys_rst, .serial_enable_n, .serial_clk,
	.ref_mode_pin_external, .low_speed_mode, .output_buffer_powerdown, .core_powerdown,
	.reference_powerdown, .quick_wake, .external_reference, .cmos_mode,
	.rise_shift_26ths, .rise_aligned, .fall_shift_26ths);
